/* File: rtl/mpl_pkg.sv */
package mpl_pkg;
   // lane counts: equal in and out, so the output rate ratio m/n is one
   localparam int LANES  = 4;
   localparam int ERR_W  = 16;
   localparam int SYNC_W = 2 * LANES + LANES + 3;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL1    = 8'h00;
   localparam logic [7:0] OFS_LB_ABIL  = 8'h04;
   localparam logic [7:0] OFS_RLB_ABIL = 8'h08;
   localparam logic [7:0] OFS_PAT_ABIL = 8'h0c;
   localparam logic [7:0] OFS_PAT_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [3:0] OFS_ERR_HI   = 4'h2;

   // field positions
   localparam int CTRL_LOCAL_LB  = 0;
   localparam int CTRL_REMOTE_LB = 1;
   localparam int LB_ABIL_BIT    = 0;
   localparam int RLB_ABIL_BIT   = 15;
   localparam int PAT_LONG_SEL   = 7;
   localparam int PAT_TX_GEN     = 3;
   localparam int PAT_TX_CHK     = 2;
   localparam int PAT_RX_GEN     = 1;
   localparam int STAT_SIG_OK    = 0;

   // reset values and constant read values
   localparam logic [1:0]  CTRL1_RST     = 2'h0;
   localparam logic [7:0]  PAT_CTRL_RST  = 8'h00;
   localparam logic [7:0]  PAT_CTRL_MASK = 8'h8e;
   localparam logic [31:0] PAT_ABIL_VAL  = 32'h0000_000e;

   // checker must see a full register of bits before judging
   localparam logic [4:0] CHK_FILL = 5'h1f;

   // distinct nonzero seeds, tx lanes first then rx lanes
   localparam logic [30:0] SEED [2*LANES] = '{
      31'h1f3a_5c21, 31'h2b61_9e07, 31'h0d4c_73f5, 31'h3e18_a6b9,
      31'h15e7_40cd, 31'h3092_b85e, 31'h0a5f_1d63, 31'h27c3_e90b};

   // status levels coming up from the lower interface
   typedef struct packed {
      logic             lower_ok;
      logic [LANES-1:0] cdr_lock;
      logic             deskew_ready;
   } mpl_link_stat_t;
endpackage : mpl_pkg

/* File: rtl/mpl_core.sv */
`timescale 1ns/100ps
// Operation
// [RULE1] output lanes run at m/n input rate
// [RULE2] output lanes may be clocked independently
// [RULE3] derive client status from lower status
// [RULE4] lock and deskew fill gate good status
// [RULE5] local loopback offered, behaves as described
// [RULE6] local loopback returns tx bits lane-wise
// [RULE7] tx muxing continues during local loopback
// [RULE8] local loopback ability flag read-only
// [RULE9] control bit enters and leaves local loopback
// [RULE10] remote loopback returns rx bits lane-wise
// [RULE11] rx muxing continues during remote loopback
// [RULE12] remote ability flag and control bit
// [RULE13] remote loopback sits near medium attachment
// [RULE14] generator ability flags read-only
// [RULE15] checker ability flags read-only
// [RULE16] select plus tx generate sends pattern down
// [RULE17] lanes use independent pattern seeds
// [RULE18] select plus rx generate sends pattern up
// [RULE19] rx generator forces good status upward
// [RULE20] generator off resumes normal muxing
// [RULE21] select plus tx check checks client lanes
// [RULE22] count one per isolated bit error
// [RULE23] muxing continues; disabled check stops counting
// [RULE24] tx check bit two, select bit seven
// [RULE25] polynomial x31+x28+1, self-synchronising checker
// [RULE26] pattern beats loopback on same lanes
module mpl_core (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // lane bit clock and lanes, all asynchronous
   input  wire logic                         lane_clk,
   input  wire logic [mpl_pkg::LANES-1:0]    tx_in,
   input  wire logic [mpl_pkg::LANES-1:0]    rx_in,
   input  wire mpl_pkg::mpl_link_stat_t      link_stat,
   // lanes out
   output logic                              lane_clk_out,
   output logic      [mpl_pkg::LANES-1:0]    tx_out,
   output logic      [mpl_pkg::LANES-1:0]    rx_out,
   output logic                              sig_ok
);
   localparam int L = mpl_pkg::LANES;
   localparam int W = mpl_pkg::SYNC_W;
   localparam int ERR_W_C = mpl_pkg::ERR_W;   // error counter width

   // three-stage synchronisers and agreement filter
   logic [W-1:0] sync0_ff;      // first stage, read only by second
   logic [W-1:0] sync1_ff;
   logic [W-1:0] sync2_ff;
   logic [W-1:0] filt_ff;       // accepted levels
   logic [W-1:0] nxt_filt;
   wire  [W-1:0] async_in = {lane_clk, tx_in, rx_in, link_stat};

   // a bit only changes once stages two and three agree
   generate
      for (genvar b = 0; b < W; b++) begin : g_filt
         assign nxt_filt[b] = (sync1_ff[b] == sync2_ff[b]) ? sync2_ff[b] : filt_ff[b];
      end
   endgenerate

   // synchroniser chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync0_ff <= '0;
         sync1_ff <= '0;
         sync2_ff <= '0;
         filt_ff  <= '0;
      end else begin
         sync0_ff <= async_in;
         sync1_ff <= sync0_ff;
         sync2_ff <= sync1_ff;
         filt_ff  <= nxt_filt;
      end
   end

   // unpack filtered view
   wire                         clk_now  = nxt_filt[W-1];
   wire                         clk_old  = filt_ff[W-1];
   wire [L-1:0]                 tx_s     = nxt_filt[W-2 -: L];
   wire [L-1:0]                 rx_s     = nxt_filt[W-2-L -: L];
   mpl_pkg::mpl_link_stat_t     st_s;
   assign st_s = nxt_filt[L+1:0];
   // lane data is taken at the accepted rising edge of the lane clock
   wire                         bit_edge = clk_now & ~clk_old;

   // registers
   logic [1:0]         ctrl1_ff;     // loopback enables
   logic [7:0]         pat_ctrl_ff;  // test-pattern control
   logic [31:0]        prdata_ff;
   logic               pready_ff;
   logic               pslverr_ff;
   logic               sig_ok_ff;
   logic               lclk_out_ff;
   logic [L-1:0]       tx_out_ff;
   logic [L-1:0]       rx_out_ff;
   logic [L-1:0]       nxt_tx;
   logic [L-1:0]       nxt_rx;
   logic [L-1:0]       err_rd;       // clear strobes per counter
   logic [ERR_W_C-1:0] err_cnt [L];

   // mode decode
   wire lb_local  = ctrl1_ff[mpl_pkg::CTRL_LOCAL_LB];
   wire lb_remote = ctrl1_ff[mpl_pkg::CTRL_REMOTE_LB];
   wire long_sel  = pat_ctrl_ff[mpl_pkg::PAT_LONG_SEL];
   wire tx_gen_on = long_sel & pat_ctrl_ff[mpl_pkg::PAT_TX_GEN];    // RULE16
   wire rx_gen_on = long_sel & pat_ctrl_ff[mpl_pkg::PAT_RX_GEN];    // RULE18
   wire tx_chk_on = long_sel & pat_ctrl_ff[mpl_pkg::PAT_TX_CHK];    // RULE24

   // apb phases: one wait state, so pready comes from a flop
   wire apb_acc   = psel & penable & ~pready_ff;
   wire apb_done  = psel & penable & pready_ff;
   wire apb_wr    = apb_done & pwrite;
   wire apb_rd    = apb_done & ~pwrite;

   // address decode
   wire hit_ctrl  = (paddr == mpl_pkg::OFS_CTRL1);
   wire hit_lab   = (paddr == mpl_pkg::OFS_LB_ABIL);
   wire hit_rlab  = (paddr == mpl_pkg::OFS_RLB_ABIL);
   wire hit_pab   = (paddr == mpl_pkg::OFS_PAT_ABIL);
   wire hit_pctl  = (paddr == mpl_pkg::OFS_PAT_CTRL);
   wire hit_stat  = (paddr == mpl_pkg::OFS_STATUS);
   wire hit_err   = (paddr[7:4] == mpl_pkg::OFS_ERR_HI) && (paddr[1:0] == 2'h0);
   wire [1:0] eix = paddr[3:2];
   wire hit_any   = hit_ctrl | hit_lab | hit_rlab | hit_pab | hit_pctl | hit_stat | hit_err;

   // read mux; unmapped reads give zero
   wire [31:0] rd_val =
      hit_ctrl ? {30'h0, ctrl1_ff} :
      hit_lab  ? (32'h1 << mpl_pkg::LB_ABIL_BIT) :                  // RULE8
      hit_rlab ? (32'h1 << mpl_pkg::RLB_ABIL_BIT) :                 // RULE12
      hit_pab  ? mpl_pkg::PAT_ABIL_VAL :                             // RULE14 RULE15
      hit_pctl ? {24'h0, pat_ctrl_ff} :
      hit_stat ? {31'h0, sig_ok_ff} :
      hit_err  ? {16'h0, err_cnt[eix]} :
                 32'h0;

   // bus answer flops; data is stable for the whole ready cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= apb_acc;
         prdata_ff  <= apb_acc ? (pwrite ? 32'h0 : rd_val) : prdata_ff;
         pslverr_ff <= apb_acc & ~hit_any;
      end
   end

   // control registers change only on the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_ff    <= mpl_pkg::CTRL1_RST;
         pat_ctrl_ff <= mpl_pkg::PAT_CTRL_RST;
      end else begin
         if (apb_wr && hit_ctrl)
            ctrl1_ff <= pwdata[1:0];                                 // RULE9 RULE12 RULE5
         if (apb_wr && hit_pctl)
            pat_ctrl_ff <= pwdata[7:0] & mpl_pkg::PAT_CTRL_MASK;
      end
   end

   // per-lane generators, checker and counters
   generate
      for (genvar i = 0; i < L; i++) begin : g_lane
         logic [30:0]        gtx_ff;   // pattern toward lower interface
         logic [30:0]        grx_ff;   // pattern toward client
         logic [30:0]        chk_ff;   // last client bits, predicted bits once full
         logic [4:0]         fill_ff;  // bits seen since check start
         logic [ERR_W_C-1:0] cnt_ff;
         // x31 + x28 + 1 feedback
         wire gtx_bit = gtx_ff[30] ^ gtx_ff[27];                     // RULE25
         wire grx_bit = grx_ff[30] ^ grx_ff[27];
         wire pred    = chk_ff[30] ^ chk_ff[27];
         wire full    = (fill_ff == mpl_pkg::CHK_FILL);
         wire err     = bit_edge & tx_chk_on & full & (tx_s[i] != pred); // RULE21
         wire sat     = &cnt_ff;
         assign err_rd[i]  = apb_rd & hit_err & (eix == 2'(i));
         assign err_cnt[i] = cnt_ff;
         // pattern wins over loopback on the same lane
         assign nxt_tx[i] = tx_gen_on ? gtx_bit :                    // RULE26 RULE20
                            lb_remote ? rx_s[i] : tx_s[i];           // RULE10 RULE7 RULE13
         assign nxt_rx[i] = rx_gen_on ? grx_bit :
                            lb_local  ? tx_s[i] : rx_s[i];           // RULE6 RULE11

         // generator state runs only while its pattern is sent
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               gtx_ff <= mpl_pkg::SEED[i];                           // RULE17
               grx_ff <= mpl_pkg::SEED[L+i];
            end else begin
               if (bit_edge && tx_gen_on)
                  gtx_ff <= {gtx_ff[29:0], gtx_bit};
               if (bit_edge && rx_gen_on)
                  grx_ff <= {grx_ff[29:0], grx_bit};
            end
         end

         // checker reseeds from the data itself, then judges
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chk_ff  <= 31'h0;
               fill_ff <= 5'h0;
            end else if (!tx_chk_on) begin
               fill_ff <= 5'h0;                                      // RULE23
            end else if (bit_edge) begin
               // once locked the predicted bit is kept, so one flipped bit counts
               // once instead of three times; a stream that never locks needs the
               // check to be switched off and on again
               chk_ff  <= {chk_ff[29:0], full ? pred : tx_s[i]};     // RULE25 RULE22
               fill_ff <= full ? fill_ff : fill_ff + 5'h1;
            end
         end

         // clear on read; an error in the read cycle still counts
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               cnt_ff <= '0;
            else if (err_rd[i])
               cnt_ff <= err ? ERR_W_C'(1) : '0;
            else if (err && !sat)
               cnt_ff <= cnt_ff + ERR_W_C'(1);                       // RULE22
         end
      end
   endgenerate

   // lane outputs and regenerated clock; one clock serves all lanes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_out_ff   <= '0;
         rx_out_ff   <= '0;
         lclk_out_ff <= 1'b0;
         sig_ok_ff   <= 1'b0;
      end else begin
         lclk_out_ff <= clk_now;                                     // RULE1 RULE2
         if (bit_edge) begin
            tx_out_ff <= nxt_tx;
            rx_out_ff <= nxt_rx;
         end
         // status logic: lower status, lane locks and deskew fill
         sig_ok_ff <= rx_gen_on |                                    // RULE19
                      (st_s.lower_ok & (&st_s.cdr_lock)              // RULE3
                       & st_s.deskew_ready);                         // RULE4
      end
   end

   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign lane_clk_out = lclk_out_ff;
   assign tx_out       = tx_out_ff;
   assign rx_out       = rx_out_ff;
   assign sig_ok       = sig_ok_ff;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_apb_wait;
      apb_acc ##1 pready_ff;
   endsequence

   chk_apb_one_wait: assert property ( // RULE9
      apb_acc |=> pready_ff ##1 !pready_ff)
      else $error("ready not a single cycle after access");

   chk_ctrl_write: assert property ( // RULE9
      s_apb_wait ##0 (apb_wr && hit_ctrl) |=>
      ctrl1_ff == $past(pwdata[1:0]))
      else $error("loopback control not written");

   chk_pat_abil: assert property ( // RULE14
      apb_acc && !pwrite && hit_pab |=> prdata_ff == 32'h0000_000e)
      else $error("pattern ability value wrong");

   chk_local_loop: assert property ( // RULE6
      bit_edge && lb_local && !rx_gen_on |=> rx_out_ff == $past(tx_s))
      else $error("local loopback lost data");

   chk_tx_keeps_mux: assert property ( // RULE7
      bit_edge && lb_local && !lb_remote && !tx_gen_on |=> tx_out_ff == $past(tx_s))
      else $error("tx path broken in local loopback");

   chk_remote_loop: assert property ( // RULE10
      bit_edge && lb_remote && !tx_gen_on |=> tx_out_ff == $past(rx_s))
      else $error("remote loopback lost data");

   chk_rx_keeps_mux: assert property ( // RULE11
      bit_edge && lb_remote && !lb_local && !rx_gen_on |=> rx_out_ff == $past(rx_s))
      else $error("rx path broken in remote loopback");

   chk_forced_ok: assert property ( // RULE19
      rx_gen_on |=> sig_ok_ff)
      else $error("status not forced good");

   chk_err_count: assert property ( // RULE22
      g_lane[0].err && !err_rd[0] && !g_lane[0].sat |=>
      err_cnt[0] == $past(err_cnt[0]) + 16'h1)
      else $error("error not counted");

   chk_count_stops: assert property ( // RULE23
      !tx_chk_on && !err_rd[0] |=> $stable(err_cnt[0]))
      else $error("counting while check disabled");

   chk_pattern_out: assert property ( // RULE16
      bit_edge && tx_gen_on |=> tx_out_ff[0] == $past(g_lane[0].gtx_bit))
      else $error("tx pattern not sent");

   // receive-direction pattern reaches client lane 0
   chk_rx_pattern_out: assert property ( // RULE18
      bit_edge && rx_gen_on |=> rx_out_ff[0] == $past(g_lane[0].grx_bit))
      else $error("rx pattern not sent");

   // with the generators off and no loopback into a direction, that direction carries ordinary traffic
   chk_tx_gen_off: assert property ( // RULE20
      bit_edge && !tx_gen_on && !lb_remote |=> tx_out_ff == $past(tx_s))
      else $error("tx traffic not resumed");

   chk_rx_gen_off: assert property ( // RULE20
      bit_edge && !rx_gen_on && !lb_local |=> rx_out_ff == $past(rx_s))
      else $error("rx traffic not resumed");

   // status follows the lower interface unless the rx generator forces it
   chk_sig_derive: assert property ( // RULE3
      !rx_gen_on |=> sig_ok_ff == $past(st_s.lower_ok && (&st_s.cdr_lock) && st_s.deskew_ready))
      else $error("status not derived from lower status");

   // a read empties the counter unless an error lands in that cycle
   chk_err_clear: assert property ( // RULE22
      err_rd[0] && !g_lane[0].err |=> err_cnt[0] == '0)
      else $error("error counter not cleared");

   // ability flag reads as a constant one
   chk_lb_abil: assert property ( // RULE8
      apb_acc && !pwrite && hit_lab |=> prdata_ff == (32'h1 << mpl_pkg::LB_ABIL_BIT))
      else $error("local loopback ability wrong");
endmodule : mpl_core

/* File: verif/mpl_lower_model.sv */
`timescale 1ns/100ps
// lower service interface: lane clock, receive lanes and link status
module mpl_lower_model (
   // bench requests
   input  wire logic                      pclk,
   input  wire logic [mpl_pkg::LANES-1:0] rx_val,
   input  wire mpl_pkg::mpl_link_stat_t   stat_val,
   // lines into the block
   output logic                           lane_clk,
   output logic      [mpl_pkg::LANES-1:0] rx_in,
   output mpl_pkg::mpl_link_stat_t        link_stat
);
   // free-running lane clock, phase unrelated to pclk
   initial begin
      lane_clk = 1'b0;
      rx_in = '0;
      link_stat = '0;
      #7;
      forever #80 lane_clk = ~lane_clk;
   end
   // new bit launched mid-period so it stands still around each rise
   always @(negedge lane_clk) begin
      @(posedge pclk);
      rx_in <= rx_val;
   end
   // status levels follow the bench
   always @(posedge pclk) link_stat <= stat_val;
endmodule : mpl_lower_model

/* File: verif/mpl_core_test.sv */
`timescale 1ns/100ps
module mpl_core_test;
   logic                      pclk = 1'b0, presetn = 1'b0;
   logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]                paddr = 8'h00;
   logic [31:0]               pwdata = 32'h0, prdata, rd;
   logic                      pready, pslverr, err, lane_clk, lane_clk_out, sig_ok;
   logic [mpl_pkg::LANES-1:0] tx_in = '0, rx_val = '0, tx_out, rx_out, rx_in, prev;
   mpl_pkg::mpl_link_stat_t   stat_val = '0, link_stat;
   int                        miscompares = 0, comparisons = 0;
   logic                      strm_on = 1'b0; // tx lanes carry a pattern
   logic [mpl_pkg::LANES-1:0] flip = '0;      // one-shot bit error per lane
   logic [30:0]               hist [mpl_pkg::LANES];

   always #10 pclk = ~pclk;

   mpl_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .lane_clk, .tx_in, .rx_in, .link_stat, .lane_clk_out, .tx_out,
      .rx_out, .sig_ok);
   mpl_lower_model lower_u (.pclk, .rx_val, .stat_val, .lane_clk, .rx_in, .link_stat);

   // next bit of x31+x28+1 from the last 31 bits, newest in bit 0
   function automatic logic pbit(input logic [30:0] h);
      return h[30] ^ h[27];
   endfunction : pbit

   // tx stream: flipped bits stay out of the history so errors stay isolated
   always @(negedge lane_clk) begin
      @(posedge pclk);
      if (strm_on) begin
         for (int l = 0; l < mpl_pkg::LANES; l++) begin
            hist[l] = {hist[l][29:0], pbit(hist[l])};
            tx_in[l] <= hist[l][0] ^ flip[l];
         end
         flip <= '0;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // the slave answers in the second access cycle
      chk(32'(n), 32'h2, "wait states");
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "read");
   endtask : rdc

   // set mode and lanes, let three lane bits pass, compare both outputs
   task automatic path(input logic [1:0] c, input logic [3:0] t, r, et, er);
      wr(mpl_pkg::OFS_CTRL1, {30'h0, c});
      @(posedge pclk);
      tx_in <= t;
      rx_val <= r;
      repeat (3) @(posedge lane_clk);
      chk({28'h0, tx_out}, {28'h0, et}, "tx_out");
      chk({28'h0, rx_out}, {28'h0, er}, "rx_out");
      // output clock is a delayed copy of the lane clock at the same rate
      chk({31'h0, lane_clk_out}, 32'h0, "clk out low");
      @(negedge lane_clk);
      chk({31'h0, lane_clk_out}, 32'h1, "clk out high");
   endtask : path

   // outputs are steady at a lane rise; check the recurrence on every lane
   task automatic pat_chk(input logic up, input string what);
      logic [30:0]               h [mpl_pkg::LANES];
      logic [mpl_pkg::LANES-1:0] b;
      int                        bad;
      bad = 0;
      repeat (4) @(posedge lane_clk);
      for (int k = 0; k < 70; k++) begin
         @(posedge lane_clk);
         b = up ? rx_out : tx_out;
         for (int l = 0; l < mpl_pkg::LANES; l++) begin
            if (k >= 31 && b[l] !== pbit(h[l])) bad++;
            h[l] = {h[l][29:0], b[l]};
         end
      end
      chk(32'(bad), 32'h0, what);
      chk({31'h0, h[0] === h[1] || h[2] === h[3] || h[0] === '0}, 32'h0, what);
   endtask : pat_chk

   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // watchdog: the tests need well under a quarter of this
   initial begin
      #400_000;
      miscompares++;
      test_done;
   end

   initial begin
      logic [7:0]  ofs [5];
      logic [31:0] e0 [5];
      logic [31:0] e1 [5];
      ofs = '{mpl_pkg::OFS_CTRL1, mpl_pkg::OFS_LB_ABIL, mpl_pkg::OFS_RLB_ABIL,
              mpl_pkg::OFS_PAT_ABIL, mpl_pkg::OFS_PAT_CTRL};
      e0 = '{32'h0, 32'h1, 32'h8000, 32'he, 32'h0};
      e1 = '{32'h3, 32'h1, 32'h8000, 32'he, 32'h8e};
      hist = '{31'h0000_0001, 31'h0000_1234, 31'h0055_0f0f, 31'h7fff_fffe};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then all-ones writes: read-only fields must not move
      for (int i = 0; i < 5; i++) begin
         rdc(ofs[i], e0[i]);
         wr(ofs[i], 32'hffff_ffff);
         rdc(ofs[i], e1[i]);
      end
      apb(1'b0, 8'h3c, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h0);
      $display("test registers done");
      // each status condition alone must drop the good indication
      for (int i = 0; i <= 6; i++) begin
         @(posedge pclk);
         stat_val <= 6'h3f & ~(6'h01 << i);
         repeat (10) @(posedge pclk);
         chk({31'h0, sig_ok}, {31'h0, i == 6}, "sig_ok");
      end
      rdc(mpl_pkg::OFS_STATUS, 32'h1);
      $display("test status done");
      path(2'h0, 4'ha, 4'h5, 4'ha, 4'h5);
      path(2'h1, 4'h3, 4'h5, 4'h3, 4'h3);
      path(2'h0, 4'h3, 4'h5, 4'h3, 4'h5);
      path(2'h2, 4'hc, 4'h6, 4'h6, 4'h6);
      path(2'h3, 4'h9, 4'h6, 4'h6, 4'h9);
      $display("test loopback done");
      // generate without select leaves normal traffic
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h08);
      path(2'h2, 4'h9, 4'h6, 4'h6, 4'h6);
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h88);
      pat_chk(1'b0, "tx pattern");
      chk({28'h0, rx_out}, {28'h0, rx_val}, "rx_out");
      // rx pattern over local loopback, status forced good with link down
      stat_val <= '0;
      wr(mpl_pkg::OFS_CTRL1, 32'h1);
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h82);
      pat_chk(1'b1, "rx pattern");
      rdc(mpl_pkg::OFS_STATUS, 32'h1);
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h0);
      path(2'h0, 4'h5, 4'ha, 4'h5, 4'ha);
      rdc(mpl_pkg::OFS_STATUS, 32'h0);
      $display("test generators done");
      // checker: fill, clear, one isolated error on lane 1
      strm_on <= 1'b1;
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h84);
      repeat (40) @(posedge lane_clk);
      for (int l = 0; l < 4; l++) rdc({mpl_pkg::OFS_ERR_HI, 2'(l), 2'b00}, 32'h0);
      @(posedge lane_clk);
      prev = tx_in;
      for (int k = 0; k < 3; k++) begin
         @(posedge lane_clk);
         chk({28'h0, tx_out}, {28'h0, prev}, "tx mux");
         prev = tx_in;
      end
      flip <= 4'h2;
      repeat (40) @(posedge lane_clk);
      for (int l = 0; l < 4; l++) rdc({mpl_pkg::OFS_ERR_HI, 2'(l), 2'b00}, {31'h0, l == 1});
      // disabled checker ignores errors
      wr(mpl_pkg::OFS_PAT_CTRL, 32'h80);
      @(posedge lane_clk);
      flip <= 4'hf;
      repeat (40) @(posedge lane_clk);
      for (int l = 0; l < 4; l++) rdc({mpl_pkg::OFS_ERR_HI, 2'(l), 2'b00}, 32'h0);
      $display("test checker done");
      test_done;
   end
endmodule : mpl_core_test
